//--- rtl/phy_diag_defines.svh
// Purpose: offsets, field positions and reset values of the diagnostic register bank
// Assumes: register index times four gives the byte address
// Notes:   definitions only
`ifndef PHY_DIAG_DEFINES_SVH
`define PHY_DIAG_DEFINES_SVH
`define IDX_TSC   10'h01A
`define IDX_STE   10'h01B
`define IDX_STL   10'h01C
`define IDX_CDC   10'h01D
`define IDX_IST   10'h020
`define IDX_IMK   10'h021
`define B_LOWTH   13
`define B_SQ_HI   12
`define B_SQ_LO   9
`define B_LPOFF   7
`define B_POL     4
`define B_JAB     0
`define B_CAPT    15
`define B_ERR_HI  15
`define B_ERR_LO  8
`define B_START   15
`define B_LQ_HI   9
`define B_LQ_LO   8
`define B_DONE    1
`define B_FAIL    0
`define RST_GAP   8'h7D
`define RST_PKT   11'h5DC
`define N_EVT     3
`define EV_DONE   0
`define EV_FAIL   1
`define EV_POL    2
`endif

//--- rtl/phy_diag_pkg.sv
// Purpose: shared types of the diagnostic register bank
// Assumes: nothing
// Notes:   states are one-hot
package phy_diag_pkg;
    typedef enum logic [2:0] {
        DG_IDLE = 3'b001,
        DG_RUN  = 3'b010,
        DG_END  = 3'b100
    } diag_state_t;
    typedef logic [15:0] reg16_t;
endpackage : phy_diag_pkg

//--- rtl/errcnt_if.sv
// Purpose: carries the self-test error counter controls and result
// Assumes: one clock domain
// Notes:   snapshot is the software-visible count
`timescale 1ns/1ps
interface errcnt_if;
    logic       err_byte;
    logic       count_mode;
    logic       capture;
    logic       clear;
    logic [7:0] snapshot;
    modport counter (input err_byte, input count_mode, input capture, input clear, output snapshot);
    modport ctrl    (output err_byte, output count_mode, output capture, output clear, input snapshot);
endinterface : errcnt_if

//--- rtl/selftest_err_counter.sv
// Purpose: running count of erroneous self-test bytes with a frozen copy
// Assumes: err_byte is a one-cycle pulse per bad byte
// Notes:   mode zero saturates, otherwise wraps
`timescale 1ns/1ps
module selftest_err_counter
    import phy_diag_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // controls and result
    errcnt_if.counter ec
);
    logic [7:0] count_r;
    logic [7:0] count_nxt;
    logic [7:0] snap_r;

    always_comb begin
        count_nxt = count_r;
        if (ec.clear) begin
            count_nxt = 8'h00;
        end else if (ec.err_byte) begin
            if (!ec.count_mode && count_r == 8'hFF) begin
                count_nxt = 8'hFF;
            end else begin
                count_nxt = count_r + 8'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= 8'h00;
        end else begin
            count_r <= count_nxt;
        end
    end

    // frozen copy, refreshed only by a write to the register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            snap_r <= 8'h00;
        end else if (ec.capture) begin
            snap_r <= count_r;
        end
    end

    assign ec.snapshot = snap_r;

    sat_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (count_r == 8'hFF && !ec.count_mode && ec.err_byte && !ec.clear) |=> count_r == 8'hFF)
        else $error("error counter wrapped in saturating mode");
    clear_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        ec.clear |=> count_r == 8'h00)
        else $error("error counter not cleared");
    snap_frozen_a: assert property (@(posedge clk) disable iff (!rst_n)
        !ec.capture |=> $stable(snap_r))
        else $error("reported error count changed without a write");
endmodule : selftest_err_counter

//--- rtl/phy_diag_regs.sv
// Purpose: 10M control, self-test and cable diagnostic registers on APB
// Assumes: inputs synchronous to clk; engines outside give pulses
// Notes:   no wait state, pready high in the first access cycle
// Behaviour
// - bit 13 lowers the 10M receive threshold
// - bits 12:9 set squelch, 50mV steps
// - bit 7 stops link pulse transmission
// - bit 4 reports inverted receive polarity
// - polarity mirrored out; own read clears it
// - bit 0 disables jabber, 10M only
// - reserved bits ignore writes, read zero
// - bits 15:8 hold checker error byte count
// - count saturates at 0xFF in mode zero
// - any write captures, bit 15 also clears counter
// - bits 7:0 set inter-packet gap, 125
// - bits 10:0 set packet length, 1500
// - start bit self-clears when measurement done
// - bits 9:8 report link quality
// - done flag reads 1 after completion
// - fail flag reads 1 after failure
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`include "phy_diag_defines.svh"
module phy_diag_regs
    import phy_diag_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // apb slave
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // 10M receiver and transmitter
    input  wire logic        speed_10m,
    input  wire logic        pol_inverted,
    output logic             low_rx_threshold_enable,
    output logic [3:0]       squelch_step,
    output logic             link_pulse_tx_off,
    output logic             jabber_off,
    output logic             pol_status,
    // self-test datapath
    input  wire logic        err_byte,
    input  wire logic        error_count_mode,
    output logic [7:0]       selftest_gap_bytes,
    output logic [10:0]      selftest_pkt_bytes,
    // cable diagnostics
    input  wire logic        diag_done_evt,
    input  wire logic        diag_fail_evt,
    input  wire logic [1:0]  link_quality,
    output logic             diag_start,
    // interrupt
    output logic             irq
);
    function automatic logic hit(input logic [11:0] a, input logic [9:0] idx);
        return a[11:2] == idx;
    endfunction : hit

    logic              pready_r;
    reg16_t            prdata_r;
    logic              pslverr_r;
    reg16_t            rdata_nxt;
    logic              mapped;
    logic              setup;
    logic              acc;
    logic              wr;
    logic              rd;
    logic              lowth_r;
    logic [3:0]        sq_r;
    logic              lpoff_r;
    logic              jab_r;
    logic              pol_r;
    logic [7:0]        gap_r;
    logic [10:0]       pkt_r;
    diag_state_t       dg_r;
    logic              done_r;
    logic              fail_r;
    logic [`N_EVT-1:0] ist_r;
    logic [`N_EVT-1:0] imk_r;
    logic [`N_EVT-1:0] evt;
    logic              start_wr;

    errcnt_if ec ();

    assign setup  = psel & ~penable;
    assign acc    = psel & penable & pready_r;
    assign wr     = acc & pwrite;
    assign rd     = acc & ~pwrite;
    assign mapped = hit(paddr, `IDX_TSC) | hit(paddr, `IDX_STE) | hit(paddr, `IDX_STL)
                  | hit(paddr, `IDX_CDC) | hit(paddr, `IDX_IST) | hit(paddr, `IDX_IMK);

    // read mux, reserved bits zero
    always_comb begin
        rdata_nxt = 16'h0000;
        if (hit(paddr, `IDX_TSC)) begin
            rdata_nxt[`B_LOWTH]           = lowth_r;
            rdata_nxt[`B_SQ_HI:`B_SQ_LO]  = sq_r;
            rdata_nxt[`B_LPOFF]           = lpoff_r;
            rdata_nxt[`B_POL]             = pol_r;
            rdata_nxt[`B_JAB]             = jab_r;
        end else if (hit(paddr, `IDX_STE)) begin
            rdata_nxt[`B_ERR_HI:`B_ERR_LO] = ec.snapshot;
            rdata_nxt[7:0]                 = gap_r;
        end else if (hit(paddr, `IDX_STL)) begin
            rdata_nxt[10:0] = pkt_r;
        end else if (hit(paddr, `IDX_CDC)) begin
            rdata_nxt[`B_START]           = (dg_r == DG_RUN);
            rdata_nxt[`B_LQ_HI:`B_LQ_LO]  = link_quality;
            rdata_nxt[`B_DONE]            = done_r;
            rdata_nxt[`B_FAIL]            = fail_r;
        end else if (hit(paddr, `IDX_IST)) begin
            rdata_nxt[`N_EVT-1:0] = ist_r;
        end else if (hit(paddr, `IDX_IMK)) begin
            rdata_nxt[`N_EVT-1:0] = imk_r;
        end
    end

    // apb answer registered at setup, no wait state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_r  <= 1'b0;
            prdata_r  <= 16'h0000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= setup;
            if (setup) begin
                prdata_r  <= rdata_nxt;
                pslverr_r <= ~mapped;
            end
        end
    end

    assign pready  = pready_r;
    assign prdata  = {16'h0000, prdata_r};
    assign pslverr = pslverr_r;

    // 10M control fields
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lowth_r <= 1'b0;
            sq_r    <= 4'h0;
            lpoff_r <= 1'b0;
            jab_r   <= 1'b0;
        end else if (wr && hit(paddr, `IDX_TSC)) begin
            lowth_r <= pwdata[`B_LOWTH];
            sq_r    <= pwdata[`B_SQ_HI:`B_SQ_LO];
            lpoff_r <= pwdata[`B_LPOFF];
            jab_r   <= pwdata[`B_JAB];
        end
    end

    // polarity flag, a new detection wins over the read clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pol_r <= 1'b0;
        end else if (pol_inverted) begin
            pol_r <= 1'b1;
        end else if (rd && hit(paddr, `IDX_TSC) && prdata_r[`B_POL]) begin
            pol_r <= 1'b0;
        end
    end

    assign low_rx_threshold_enable = lowth_r;
    assign squelch_step            = sq_r;
    assign link_pulse_tx_off       = lpoff_r;
    assign jabber_off              = jab_r & speed_10m;
    assign pol_status              = pol_r;

    // self-test settings
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_r <= `RST_GAP;
        end else if (wr && hit(paddr, `IDX_STE)) begin
            gap_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pkt_r <= `RST_PKT;
        end else if (wr && hit(paddr, `IDX_STL)) begin
            pkt_r <= pwdata[10:0];
        end
    end

    assign selftest_gap_bytes = gap_r;
    assign selftest_pkt_bytes = pkt_r;

    assign ec.err_byte   = err_byte;
    assign ec.count_mode = error_count_mode;
    assign ec.capture    = wr && hit(paddr, `IDX_STE);
    assign ec.clear      = wr && hit(paddr, `IDX_STE) && pwdata[`B_CAPT];

    selftest_err_counter u_errcnt (
        .clk   (clk),
        .rst_n (rst_n),
        .ec    (ec)
    );

    // cable diagnostic sequence
    assign start_wr = wr && hit(paddr, `IDX_CDC);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dg_r <= DG_IDLE;
        end else begin
            case (dg_r)
                DG_IDLE, DG_END: begin
                    if (start_wr && pwdata[`B_START]) begin
                        dg_r <= DG_RUN;
                    end
                end
                DG_RUN: begin
                    if (diag_done_evt) begin
                        dg_r <= DG_END;
                    end else if (start_wr && !pwdata[`B_START]) begin
                        dg_r <= DG_IDLE;
                    end
                end
                default: dg_r <= DG_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            done_r <= 1'b0;
        end else if (dg_r == DG_RUN && diag_done_evt) begin
            done_r <= 1'b1;
        end else if (dg_r != DG_RUN && start_wr && pwdata[`B_START]) begin
            done_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fail_r <= 1'b0;
        end else if (dg_r == DG_RUN && diag_fail_evt) begin
            fail_r <= 1'b1;
        end else if (dg_r != DG_RUN && start_wr && pwdata[`B_START]) begin
            fail_r <= 1'b0;
        end
    end

    assign diag_start = (dg_r == DG_RUN);

    // interrupt status, cleared by reading, set wins
    assign evt[`EV_DONE] = (dg_r == DG_RUN) && diag_done_evt;
    assign evt[`EV_FAIL] = (dg_r == DG_RUN) && diag_fail_evt;
    assign evt[`EV_POL]  = pol_inverted && !pol_r;

    generate
        for (genvar i = 0; i < `N_EVT; i++) begin : g_ist
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    ist_r[i] <= 1'b0;
                end else if (evt[i]) begin
                    ist_r[i] <= 1'b1;
                end else if (rd && hit(paddr, `IDX_IST) && prdata_r[i]) begin
                    ist_r[i] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            imk_r <= '0;
        end else if (wr && hit(paddr, `IDX_IMK)) begin
            imk_r <= pwdata[`N_EVT-1:0];
        end
    end

    assign irq = |(ist_r & imk_r);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    lowth_write_a: assert property (
        wr && hit(paddr, `IDX_TSC) |=> low_rx_threshold_enable == $past(pwdata[13]))
        else $error("threshold bit not written");
    squelch_write_a: assert property (
        wr && hit(paddr, `IDX_TSC) |=> squelch_step == $past(pwdata[12:9]))
        else $error("squelch field not written");
    pulse_off_a: assert property (
        wr && hit(paddr, `IDX_TSC) |=> link_pulse_tx_off == $past(pwdata[7]))
        else $error("link pulse control not written");
    pol_set_a: assert property (
        pol_inverted |=> pol_status)
        else $error("polarity flag not set");
    pol_clear_a: assert property (
        rd && hit(paddr, `IDX_TSC) && prdata_r[4] && !pol_inverted |=> !pol_status)
        else $error("polarity flag not cleared by read");
    jab_gate_a: assert property (
        wr && hit(paddr, `IDX_TSC) |=> jabber_off == ($past(pwdata[`B_JAB]) && speed_10m))
        else $error("jabber disable outside 10M");
    rsv_zero_a: assert property (
        pready_r && hit(paddr, `IDX_TSC) |-> prdata_r[15:14] == 2'b00 && prdata_r[8] == 1'b0
            && prdata_r[6:5] == 2'b00 && prdata_r[3:1] == 3'b000)
        else $error("reserved bits read nonzero");
    gap_write_a: assert property (
        wr && hit(paddr, `IDX_STE) |=> selftest_gap_bytes == $past(pwdata[7:0]))
        else $error("gap field not written");
    pkt_write_a: assert property (
        wr && hit(paddr, `IDX_STL) |=> selftest_pkt_bytes == $past(pwdata[10:0]))
        else $error("packet length not written");
    start_clear_a: assert property (
        diag_start && diag_done_evt |=> !diag_start && done_r)
        else $error("start not cleared on completion");
    quality_read_a: assert property (
        setup && hit(paddr, `IDX_CDC) |=> prdata_r[9:8] == $past(link_quality))
        else $error("link quality not reported");
    flag_hold_a: assert property (
        done_r && !(start_wr && pwdata[15]) |=> done_r)
        else $error("done flag lost before restart");
    fail_flag_a: assert property (
        diag_start && diag_fail_evt |=> fail_r)
        else $error("fail flag not set");
    err_read_a: assert property (
        setup && hit(paddr, `IDX_STE) |=> prdata_r[`B_ERR_HI:`B_ERR_LO] == $past(ec.snapshot))
        else $error("error count not reported");
    done_read_a: assert property (
        setup && hit(paddr, `IDX_CDC) |=> prdata_r[`B_DONE] == $past(done_r))
        else $error("done flag not reported");
    fail_read_a: assert property (
        setup && hit(paddr, `IDX_CDC) |=> prdata_r[`B_FAIL] == $past(fail_r))
        else $error("fail flag not reported");
    abort_run_a: assert property (
        diag_start && start_wr && !pwdata[`B_START] && !diag_done_evt |=> !diag_start)
        else $error("measurement not aborted");
    ist_set_a: assert property (
        |evt |=> (ist_r & $past(evt)) == $past(evt))
        else $error("interrupt status not set by event");
    rsv_cdc_a: assert property (
        pready_r && hit(paddr, `IDX_CDC) |-> prdata_r[14:10] == 5'b00000 && prdata_r[7:2] == 6'b000000)
        else $error("reserved diagnostic bits read nonzero");
    rsv_len_a: assert property (
        pready_r && hit(paddr, `IDX_STL) |-> prdata_r[15:11] == 5'b00000)
        else $error("reserved length bits read nonzero");
endmodule : phy_diag_regs

//--- tb/phy_test_diag_register_bank_bench.sv
// Purpose: self-checking bench of the diagnostic register bank over apb
// Assumes: no wait state per transfer; reads noted in a queue, checked by a monitor
// Notes:   events and random values are driven at the rising edge
`timescale 1ns/1ps
`include "phy_diag_defines.svh"
module phy_test_diag_register_bank_bench;
    import phy_diag_pkg::*;
    localparam logic [11:0] A_TSC = {`IDX_TSC, 2'b00};
    localparam logic [11:0] A_STE = {`IDX_STE, 2'b00};
    localparam logic [11:0] A_STL = {`IDX_STL, 2'b00};
    localparam logic [11:0] A_CDC = {`IDX_CDC, 2'b00};
    localparam logic [11:0] A_IST = {`IDX_IST, 2'b00};
    localparam logic [11:0] A_IMK = {`IDX_IMK, 2'b00};
    localparam logic [11:0] A_BAD = 12'h0FC;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        speed_10m = 1'b0;
    logic        pol_inverted = 1'b0;
    logic        low_rx_threshold_enable;
    logic [3:0]  squelch_step;
    logic        link_pulse_tx_off;
    logic        jabber_off;
    logic        pol_status;
    logic        err_byte = 1'b0;
    logic        error_count_mode = 1'b0;
    logic [7:0]  selftest_gap_bytes;
    logic [10:0] selftest_pkt_bytes;
    logic        diag_done_evt = 1'b0;
    logic        diag_fail_evt = 1'b0;
    logic [1:0]  link_quality = 2'b01;
    logic        diag_start;
    logic        irq;
    int          mismatches = 0;
    int          check_count = 0;
    int          cycles = 0;
    logic [31:0] seed = 32'd85668;
    logic [32:0] notes[$];
    reg16_t      v;
    reg16_t      ctl;
    phy_diag_regs phy_diag_regs_inst (
        .clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .speed_10m(speed_10m), .pol_inverted(pol_inverted),
        .low_rx_threshold_enable(low_rx_threshold_enable), .squelch_step(squelch_step),
        .link_pulse_tx_off(link_pulse_tx_off), .jabber_off(jabber_off), .pol_status(pol_status),
        .err_byte(err_byte), .error_count_mode(error_count_mode),
        .selftest_gap_bytes(selftest_gap_bytes), .selftest_pkt_bytes(selftest_pkt_bytes),
        .diag_done_evt(diag_done_evt), .diag_fail_evt(diag_fail_evt),
        .link_quality(link_quality), .diag_start(diag_start), .irq(irq));
    always #25 clk = ~clk;
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim
    task automatic chk(string name, logic [32:0] exp, logic [32:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic apb(logic wr, logic [11:0] a, reg16_t d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : apb
    task automatic wr(logic [11:0] a, reg16_t d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(logic [11:0] a, reg16_t exp);
        notes.push_back({a == A_BAD, 16'h0000, exp});
        apb(1'b0, a, 16'h0000);
    endtask : rd
    task automatic pulses(int n);
        repeat (n) begin
            @(posedge clk);
            err_byte <= 1'b1;
            @(posedge clk);
            err_byte <= 1'b0;
        end
    endtask : pulses
    task automatic evt(logic d, logic f);
        @(posedge clk);
        diag_done_evt <= d;
        diag_fail_evt <= f;
        @(posedge clk);
        diag_done_evt <= 1'b0;
        diag_fail_evt <= 1'b0;
        @(posedge clk);
        #1;
    endtask : evt
    // monitor: every completed read is matched with the oldest note
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (notes.size() == 0) begin
                chk("unexpected read", 33'h0, 33'h1);
            end else begin
                chk("read data", notes.pop_front(), {pslverr, prdata});
            end
        end
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles > 30000) begin
            mismatches++;
            end_sim();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(A_TSC, 16'h0000);
        rd(A_STE, 16'h007D);
        rd(A_STL, 16'h05DC);
        rd(A_IMK, 16'h0000);
        chk("gap out", 33'h7D, selftest_gap_bytes);
        wr(A_TSC, 16'hFFFF);
        rd(A_TSC, 16'h3E81);
        chk("jabber 100m", 33'h0, jabber_off);
        @(posedge clk);
        speed_10m <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            v = reg16_t'(xs());
            ctl = v & 16'h3E81;
            wr(A_TSC, v);
            rd(A_TSC, ctl);
            chk("low threshold", ctl[13], low_rx_threshold_enable);
            chk("squelch", ctl[12:9], squelch_step);
            chk("link pulse off", ctl[7], link_pulse_tx_off);
            chk("jabber off", ctl[0], jabber_off);
        end
        @(posedge clk);
        pol_inverted <= 1'b1;
        repeat (2) @(posedge clk);
        pol_inverted <= 1'b0;
        @(posedge clk);
        #1;
        chk("pol set", 33'h1, pol_status);
        rd(A_STE, 16'h007D);
        chk("pol kept", 33'h1, pol_status);
        rd(A_TSC, ctl | 16'h0010);
        chk("pol cleared", 33'h0, pol_status);
        rd(A_TSC, ctl);
        rd(A_IST, 16'h0004);
        pulses(5);
        rd(A_STE, 16'h007D);
        wr(A_STE, 16'h807D);
        rd(A_STE, 16'h057D);
        pulses(3);
        wr(A_STE, 16'h007D);
        rd(A_STE, 16'h037D);
        pulses(300);
        wr(A_STE, 16'h807D);
        rd(A_STE, 16'hFF7D);
        @(posedge clk);
        error_count_mode <= 1'b1;
        pulses(260);
        wr(A_STE, 16'h0000);
        rd(A_STE, 16'h0400);
        chk("gap zero", 33'h0, selftest_gap_bytes);
        @(posedge clk);
        error_count_mode <= 1'b0;
        v = reg16_t'(xs());
        wr(A_STL, v);
        rd(A_STL, v & 16'h07FF);
        chk("pkt out", v[10:0], selftest_pkt_bytes);
        for (int q = 1; q < 4; q++) begin
            @(posedge clk);
            link_quality <= q[1:0];
            rd(A_CDC, reg16_t'(q << 8));
        end
        wr(A_IMK, 16'hFFFF);
        rd(A_IMK, 16'h0007);
        wr(A_CDC, 16'hFFFF);
        chk("start", 33'h1, diag_start);
        rd(A_CDC, 16'h8300);
        evt(1'b1, 1'b1);
        chk("start done", 33'h0, diag_start);
        chk("irq up", 33'h1, irq);
        rd(A_CDC, 16'h0303);
        rd(A_IST, 16'h0003);
        chk("irq cleared", 33'h0, irq);
        rd(A_CDC, 16'h0303);
        wr(A_IMK, 16'h0002);
        wr(A_CDC, 16'h8000);
        rd(A_CDC, 16'h8300);
        evt(1'b1, 1'b0);
        chk("irq masked", 33'h0, irq);
        rd(A_CDC, 16'h0302);
        rd(A_IST, 16'h0001);
        wr(A_CDC, 16'h8000);
        wr(A_CDC, 16'h0000);
        chk("abort", 33'h0, diag_start);
        rd(A_CDC, 16'h0300);
        wr(A_BAD, 16'hFFFF);
        rd(A_BAD, 16'h0000);
        rd(A_TSC, ctl);
        repeat (2) @(posedge clk);
        chk("notes left", 33'h0, notes.size());
        end_sim();
    end
endmodule : phy_test_diag_register_bank_bench
